// [hw/frs_cfg.svh]
`ifndef FRS_CFG_SVH
`define FRS_CFG_SVH
// register byte addresses
`define FRS_ADDR_CTRL 8'h00
`define FRS_ADDR_CONFIG 8'h04
`define FRS_ADDR_SPECIFY 8'h08
`define FRS_ADDR_DATA 8'h0c
`define FRS_ADDR_ST1 8'h10
`define FRS_ADDR_ST2 8'h14
`define FRS_ADDR_ST3 8'h18
`define FRS_ADDR_STATE 8'h1c
// control and configuration register fields
`define FRS_CTRL_OUT_RST 0
`define FRS_CTRL_DSR_RST 1
`define FRS_CTRL_PWRDN 2
`define FRS_CFG_POLL_OFF 0
// reset values
`define FRS_SPECIFY_RST 8'h00
`define FRS_BYTE_ZERO 8'h00
`define FRS_WORD_ZERO 32'h0000_0000
// result status one fields
`define FRS_ST1_END 7
`define FRS_ST1_CRC 5
`define FRS_ST1_LATE 4
`define FRS_ST1_ABSENT 2
`define FRS_ST1_WRBLK 1
`define FRS_ST1_IDABS 0
// result status two fields
`define FRS_ST2_CM 6
`define FRS_ST2_DATACRC 5
`define FRS_ST2_TRKMIS 4
`define FRS_ST2_BADTRK 1
`define FRS_ST2_MARKMISS 0
// result status three fields
`define FRS_ST3_WP 6
`define FRS_ST3_ONE_HI 5
`define FRS_ST3_TRACK_ZERO_PIN 4
`define FRS_ST3_ONE_LO 3
`define FRS_ST3_HEAD 2
// constants
`define FRS_BAD_TRACK 8'hff
`define FRS_INDEX_LIMIT 2'd2
`define FRS_RESULT_LAST 2'd2
`define FRS_ONE2 2'd1
`endif

// [hw/frs_pkg.sv]
package frs_pkg;
    typedef enum logic [3:0] {
        ST_RESET = 4'b0001,
        ST_IDLE = 4'b0010,
        ST_EXEC = 4'b0100,
        ST_RESULT = 4'b1000
    } frs_state_e;

    typedef enum logic [2:0] {
        CMD_READ = 3'h0,
        CMD_READ_DEL = 3'h1,
        CMD_WRITE = 3'h2,
        CMD_WRITE_DEL = 3'h3,
        CMD_FORMAT = 3'h4,
        CMD_READ_ID = 3'h5,
        CMD_READ_TRACK = 3'h6,
        CMD_OTHER = 3'h7
    } frs_cmd_e;

    typedef struct packed {
        logic trackEndPassed;
        logic terminalCount;
        logic idCrcFail;
        logic dataCrcFail;
        logic serviceLate;
        logic sectorAbsent;
        logic idUnreadable;
        logic sequenceWrong;
        logic deletedMarkSeen;
        logic normalMarkSeen;
        logic idMarkFound;
        logic dataMarkMissing;
        logic idFieldValid;
    } frs_event_s;

    typedef struct packed {
        logic [7:0] idTrack;
        logic [7:0] presentTrack;
        logic headSelect;
        logic [1:0] driveSelect;
        logic searchingId;
    } frs_track_s;
endpackage : frs_pkg

// [hw/frs_top.sv]
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/10ps
`include "frs_cfg.svh"
// Summary of operation
// - end-of-track or missing count sets bit7
// - unused status bits read zero
// - drive status bits 5,3 always one
// - any crc failure sets bit5
// - late service sets overrun bit4
// - sector, id or sequence absent sets bit2
// - write protect during writes sets bit1
// - missing id or data mark sets bit0
// - wrong mark type sets control-mark bit6
// - data field crc failure sets bit5
// - track mismatch sets bit4
// - mismatch with all-ones track sets bit1
// - missing data mark sets bit0
// - drive status mirrors live drive pins
// - three reset sources plus power-on
// - any reset leaves power-down
// - pin reset aborts operations, stays in reset until host clears output bit
// - reset clears configuration, then waits
// - polling starts unless configuration disables it
// - pin reset keeps timing parameters
// - pin reset sets output bit; host clears
// - rate bit self-clears; output bit wins
// - status bytes read during result phase
module frs_top
    import frs_pkg::*;
(
    // clock and power-on reset
    input wire logic mclk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // controller core
    input wire logic cmdStart,
    input wire frs_cmd_e cmdKind,
    input wire logic cmdDone,
    input wire frs_event_s evt,
    input wire frs_track_s trk,
    // drive cable pins
    input wire logic writeProtectPin,
    input wire logic trackZeroPin,
    input wire logic rotationMarkerPin_n,
    input wire logic systemResetPin_n,
    // controller state
    output logic coreReset,
    output logic pollActive,
    output logic powerDown,
    output logic resultPhase
);
    frs_state_e state_reg, state_next;
    frs_cmd_e cmd_reg;
    logic [3:0] pinS1_reg, pinS2_reg, pinS3_reg, pinLvl_reg;
    logic outReset_reg, dsrReset_reg, powerDown_reg, pollOff_reg;
    logic [7:0] specify_reg;
    logic [7:0] st1_reg, st1_next, st2_reg, st2_next;
    logic countSeen_reg;
    logic [1:0] indexCnt_reg, indexCnt_next, resPtr_reg;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pslverr_reg, pslverr_next;
    logic coreReset_reg, pollActive_reg, resultPhase_reg;

    // filtered pins: wp, track_zero_pin, index_n, sysreset_n
    wire logic wpLvl = pinLvl_reg[0];
    wire logic trk0Lvl = pinLvl_reg[1];
    wire logic idxLvl_n = pinLvl_reg[2];
    wire logic pinReset = ~pinLvl_reg[3];
    wire logic idxFall = pinLvl_reg[2] & ~pinS3_reg[2] & ~pinS2_reg[2];

    // apb decode
    wire logic setup = psel & ~penable;
    wire logic wrEn = psel & penable & pready_reg & pwrite;
    wire logic rdEn = psel & penable & pready_reg & ~pwrite;
    wire logic hitCtrl = paddr == `FRS_ADDR_CTRL;
    wire logic hitCfg = paddr == `FRS_ADDR_CONFIG;
    wire logic hitSpec = paddr == `FRS_ADDR_SPECIFY;
    wire logic hitData = paddr == `FRS_ADDR_DATA;
    wire logic hitSt1 = paddr == `FRS_ADDR_ST1;
    wire logic hitSt2 = paddr == `FRS_ADDR_ST2;
    wire logic hitSt3 = paddr == `FRS_ADDR_ST3;
    wire logic hitState = paddr == `FRS_ADDR_STATE;
    wire logic addrHit = hitCtrl | hitCfg | hitSpec | hitData | hitSt1
        | hitSt2 | hitSt3 | hitState;

    // reset sources
    wire logic anyReset = pinReset | outReset_reg | dsrReset_reg;
    wire logic inExec = state_reg == ST_EXEC;
    wire logic inResult = state_reg == ST_RESULT;
    wire logic clearStatus = (state_reg == ST_IDLE) & cmdStart;

    // command classes
    wire logic isRdWrData = (cmd_reg == CMD_READ) | (cmd_reg == CMD_WRITE);
    wire logic isReadData = (cmd_reg == CMD_READ)
        | (cmd_reg == CMD_READ_DEL);
    wire logic isWriteCmd = (cmd_reg == CMD_WRITE)
        | (cmd_reg == CMD_WRITE_DEL) | (cmd_reg == CMD_FORMAT);

    // event decode, counted only while executing
    wire logic trackDiff = evt.idFieldValid
        & (trk.idTrack != trk.presentTrack);
    wire logic missEnd = cmdDone & isRdWrData & ~countSeen_reg
        & ~evt.terminalCount;
    wire logic idMissing = trk.searchingId & idxFall & ~evt.idMarkFound
        & (indexCnt_reg == `FRS_INDEX_LIMIT - `FRS_ONE2);
    wire logic [7:0] set1 = {8{inExec}} & {
        evt.trackEndPassed | missEnd,
        1'b0,
        evt.idCrcFail | evt.dataCrcFail,
        evt.serviceLate,
        1'b0,
        (isReadData & evt.sectorAbsent)
            | ((cmd_reg == CMD_READ_ID) & evt.idUnreadable)
            | ((cmd_reg == CMD_READ_TRACK) & evt.sequenceWrong),
        isWriteCmd & wpLvl,
        idMissing | evt.dataMarkMissing
    };
    wire logic [7:0] set2 = {8{inExec}} & {
        1'b0,
        ((cmd_reg == CMD_READ) & evt.deletedMarkSeen)
            | ((cmd_reg == CMD_READ_DEL) & evt.normalMarkSeen),
        evt.dataCrcFail,
        trackDiff,
        2'b00,
        trackDiff & (trk.idTrack == `FRS_BAD_TRACK),
        evt.dataMarkMissing
    };

    // live drive status
    wire logic [7:0] st3 = {1'b0, wpLvl, 1'b1, trk0Lvl, 1'b1,
        trk.headSelect, trk.driveSelect};

    // result byte selection
    wire logic [7:0] resByte = (resPtr_reg == 2'd0) ? st1_reg
        : (resPtr_reg == 2'd1) ? st2_reg : st3;
    wire logic [7:0] stateByte = {2'b00, resultPhase_reg,
        pollActive_reg, state_reg};

    // status next values, set wins over clear
    assign st1_next = (clearStatus ? `FRS_BYTE_ZERO : st1_reg) | set1;
    assign st2_next = (clearStatus ? `FRS_BYTE_ZERO : st2_reg) | set2;

    // index pulse counter while hunting an id mark
    assign indexCnt_next = (~inExec | ~trk.searchingId | evt.idMarkFound
        | idMissing) ? 2'd0 : indexCnt_reg + {1'b0, idxFall};

    // read data mux
    assign prdata_next = ~setup | pwrite ? `FRS_WORD_ZERO
        : hitCtrl ? {29'h0, powerDown_reg, dsrReset_reg, outReset_reg}
        : hitCfg ? {31'h0, pollOff_reg}
        : hitSpec ? {24'h0, specify_reg}
        : hitData ? {24'h0, inResult ? resByte : `FRS_BYTE_ZERO}
        : hitSt1 ? {24'h0, st1_reg}
        : hitSt2 ? {24'h0, st2_reg}
        : hitSt3 ? {24'h0, st3}
        : hitState ? {24'h0, stateByte}
        : `FRS_WORD_ZERO;
    assign pslverr_next = setup & ~addrHit;

    // controller state machine
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RESET: begin
                if (!anyReset) begin
                    state_next = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (cmdStart) begin
                    state_next = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (cmdDone) begin
                    state_next = ST_RESULT;
                end
            end
            ST_RESULT: begin
                if (rdEn && hitData && resPtr_reg == `FRS_RESULT_LAST) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_RESET;
            end
        endcase
        if (anyReset) begin
            state_next = ST_RESET;
        end
    end

    // pin synchronisers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pinS1_reg <= 4'hc;
            pinS2_reg <= 4'hc;
            pinS3_reg <= 4'hc;
            pinLvl_reg <= 4'hc;
        end else begin
            pinS1_reg <= {systemResetPin_n, rotationMarkerPin_n,
                trackZeroPin, writeProtectPin};
            pinS2_reg <= pinS1_reg;
            pinS3_reg <= pinS2_reg;
            for (int i = 0; i < 4; i++) begin
                if (pinS2_reg[i] == pinS3_reg[i]) begin
                    pinLvl_reg[i] <= pinS3_reg[i];
                end
            end
        end
    end

    // control registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            outReset_reg <= 1'b1;
            dsrReset_reg <= 1'b0;
            powerDown_reg <= 1'b0;
            pollOff_reg <= 1'b0;
            specify_reg <= `FRS_SPECIFY_RST;
        end else begin
            if (wrEn && hitCtrl) begin
                outReset_reg <= pwdata[`FRS_CTRL_OUT_RST];
                dsrReset_reg <= pwdata[`FRS_CTRL_DSR_RST];
                powerDown_reg <= pwdata[`FRS_CTRL_PWRDN];
            end
            if (wrEn && hitCfg) begin
                pollOff_reg <= pwdata[`FRS_CFG_POLL_OFF];
            end
            if (wrEn && hitSpec) begin
                specify_reg <= pwdata[7:0];
            end
            if (state_reg == ST_RESET) begin
                dsrReset_reg <= 1'b0;
                pollOff_reg <= 1'b0;
            end
            if (anyReset) begin
                powerDown_reg <= 1'b0;
            end
            if (pinReset) begin
                outReset_reg <= 1'b1;
            end
        end
    end

    // status and command tracking
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st1_reg <= `FRS_BYTE_ZERO;
            st2_reg <= `FRS_BYTE_ZERO;
            cmd_reg <= CMD_OTHER;
            countSeen_reg <= 1'b0;
            indexCnt_reg <= 2'd0;
            resPtr_reg <= 2'd0;
        end else if (state_reg == ST_RESET) begin
            st1_reg <= `FRS_BYTE_ZERO;
            st2_reg <= `FRS_BYTE_ZERO;
            cmd_reg <= CMD_OTHER;
            countSeen_reg <= 1'b0;
            indexCnt_reg <= 2'd0;
            resPtr_reg <= 2'd0;
        end else begin
            st1_reg <= st1_next;
            st2_reg <= st2_next;
            indexCnt_reg <= indexCnt_next;
            if (clearStatus) begin
                cmd_reg <= cmdKind;
                countSeen_reg <= 1'b0;
                resPtr_reg <= 2'd0;
            end else if (inExec && evt.terminalCount) begin
                countSeen_reg <= 1'b1;
            end
            if (inResult && rdEn && hitData) begin
                resPtr_reg <= resPtr_reg + `FRS_ONE2;
            end
        end
    end

    // state and bus outputs
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_RESET;
            prdata_reg <= `FRS_WORD_ZERO;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            coreReset_reg <= 1'b1;
            pollActive_reg <= 1'b0;
            resultPhase_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            prdata_reg <= prdata_next;
            pready_reg <= setup;
            pslverr_reg <= pslverr_next;
            coreReset_reg <= state_next == ST_RESET;
            pollActive_reg <= (state_next == ST_IDLE) & ~pollOff_reg
                & ~(wrEn & hitCfg & pwdata[`FRS_CFG_POLL_OFF]);
            resultPhase_reg <= state_next == ST_RESULT;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign coreReset = coreReset_reg;
    assign pollActive = pollActive_reg;
    assign powerDown = powerDown_reg;
    assign resultPhase = resultPhase_reg;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    end_no_tc_a: assert property (
        inExec && cmdDone && isRdWrData && !countSeen_reg
        && !evt.terminalCount && !anyReset |=> st1_reg[`FRS_ST1_END])
        else $error("end bit not set without terminal count");
    unused_zero_a: assert property (
        !st1_reg[6] && !st1_reg[3] && !st2_reg[7] && !st2_reg[3]
        && !st2_reg[2])
        else $error("unused status bit set");
    drive_ones_a: assert property (
        hitSt3 && setup && !pwrite
        |=> prdata[`FRS_ST3_ONE_HI] && prdata[`FRS_ST3_ONE_LO] && !prdata[7])
        else $error("drive status fixed bits wrong");
    crc_any_a: assert property (
        inExec && (evt.idCrcFail || evt.dataCrcFail) && !anyReset
        |=> st1_reg[`FRS_ST1_CRC])
        else $error("crc fault not reported");
    wr_block_a: assert property (
        inExec && isWriteCmd && wpLvl && !anyReset
        |=> st1_reg[`FRS_ST1_WRBLK])
        else $error("write blocked flag not set");
    data_crc_a: assert property (
        inExec && evt.dataCrcFail && !anyReset |=> st2_reg[`FRS_ST2_DATACRC])
        else $error("data field crc fault not reported");
    track_mis_a: assert property (
        inExec && trackDiff && !anyReset |=> st2_reg[`FRS_ST2_TRKMIS])
        else $error("track mismatch not reported");
    bad_track_a: assert property (
        inExec && evt.idFieldValid && trk.idTrack == `FRS_BAD_TRACK
        && trk.presentTrack != `FRS_BAD_TRACK && !anyReset
        |=> st2_reg[`FRS_ST2_BADTRK] && st2_reg[`FRS_ST2_TRKMIS])
        else $error("bad track not flagged");
    pwr_exit_a: assert property (
        anyReset |=> !powerDown)
        else $error("power down held through reset");
    pin_abort_a: assert property (
        pinReset |=> coreReset ##1 (state_reg == ST_RESET))
        else $error("pin reset did not abort");
    spec_keep_a: assert property (
        pinReset && !(wrEn && hitSpec) |=> $stable(specify_reg))
        else $error("timing parameters lost on pin reset");
    out_set_a: assert property (
        pinReset |=> outReset_reg)
        else $error("output reset bit not set by pin");
    dsr_clear_a: assert property (
        $rose(dsrReset_reg) && !(wrEn && hitCtrl) |-> ##[1:3] !dsrReset_reg)
        else $error("rate reset bit did not self clear");
    poll_start_a: assert property (
        state_reg == ST_RESET && !anyReset |=> ##1 pollActive)
        else $error("polling did not start after reset");
    result_end_a: assert property (
        inResult && rdEn && hitData && resPtr_reg == `FRS_RESULT_LAST
        && !anyReset |=> state_reg == ST_IDLE)
        else $error("result phase did not end after last byte");
endmodule : frs_top

// [verification/floppy_result_status_reset_tb.sv]
`timescale 1ns/10ps
`include "frs_cfg.svh"
`define CHK(got, exp) begin nTests++; if ((got) !== (exp)) begin \
    errorCnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module floppy_result_status_reset_tb;
    import frs_pkg::*;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdData;
    logic cmdStart, cmdDone, rdErr, idxReq, wpLevel, trk0Level;
    frs_cmd_e cmdKind;
    frs_event_s evt;
    frs_track_s trk;
    logic writeProtectPin, trackZeroPin, rotationMarkerPin_n;
    logic systemResetPin_n, coreReset, pollActive, powerDown, resultPhase;
    int errorCnt, nTests;

    frs_top uut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .cmdStart, .cmdKind, .cmdDone, .evt,
        .trk, .writeProtectPin, .trackZeroPin, .rotationMarkerPin_n,
        .systemResetPin_n, .coreReset, .pollActive, .powerDown,
        .resultPhase);
    frs_drive_model drv (.mclk, .rst, .idxReq, .wpLevel, .trk0Level,
        .writeProtectPin, .trackZeroPin, .rotationMarkerPin_n);

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic results;
        $display("compares %0d mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc

    task automatic apb(input logic [7:0] a, input logic w,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge mclk);
        end
        `CHK(pready, 1'b1)
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0000_0000);
        `CHK(rdData, exp)
    endtask : rd

    // one command with its result phase read back
    task automatic runCmd(input frs_cmd_e k, input logic [12:0] e,
        input logic [7:0] idT, input logic [7:0] s1, input logic [7:0] s2,
        input int nIdx);
        logic [7:0] s3;
        s3 = {1'b0, wpLevel, 1'b1, trk0Level, 1'b1, trk.headSelect,
            trk.driveSelect};
        @(posedge mclk);
        trk.idTrack <= idT;
        trk.searchingId <= (nIdx > 0);
        cmdStart <= 1'b1;
        cmdKind <= k;
        @(posedge mclk);
        cmdStart <= 1'b0;
        evt <= frs_event_s'(e);
        @(posedge mclk);
        evt <= '0;
        repeat (nIdx) begin
            idxReq <= 1'b1;
            @(posedge mclk);
            idxReq <= 1'b0;
            cyc(12);
        end
        cmdDone <= 1'b1;
        @(posedge mclk);
        cmdDone <= 1'b0;
        @(posedge mclk);
        `CHK(resultPhase, 1'b1)
        rd(`FRS_ADDR_ST1, {24'h0, s1});
        rd(`FRS_ADDR_ST2, {24'h0, s2});
        rd(`FRS_ADDR_DATA, {24'h0, s1});
        rd(`FRS_ADDR_DATA, {24'h0, s2});
        rd(`FRS_ADDR_DATA, {24'h0, s3});
        cyc(2);
        `CHK(resultPhase, 1'b0)
        $display("command %s done", k.name());
    endtask : runCmd

    initial begin
        repeat (20000) @(posedge mclk);
        errorCnt++;
        results();
    end

    initial begin
        errorCnt = 0;
        nTests = 0;
        rst = 1'b1;
        {psel, penable, pwrite, cmdStart, cmdDone, idxReq} = '0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        cmdKind = CMD_OTHER;
        evt = '0;
        trk = '{8'h05, 8'h05, 1'b1, 2'h2, 1'b0};
        {wpLevel, trk0Level} = 2'b00;
        systemResetPin_n = 1'b1;
        cyc(10);
        rst <= 1'b0;
        rd(`FRS_ADDR_CTRL, 32'h0000_0001);
        `CHK(coreReset, 1'b1)
        rd(8'h20, 32'h0000_0000);
        `CHK(rdErr, 1'b1)
        apb(`FRS_ADDR_CTRL, 1'b1, 32'h0000_0000);
        cyc(4);
        `CHK(coreReset, 1'b0)
        `CHK(pollActive, 1'b1)
        apb(`FRS_ADDR_CONFIG, 1'b1, 32'h0000_0001);
        cyc(2);
        `CHK(pollActive, 1'b0)
        apb(`FRS_ADDR_CTRL, 1'b1, 32'h0000_0002);
        cyc(6);
        rd(`FRS_ADDR_CTRL, 32'h0000_0000);
        rd(`FRS_ADDR_CONFIG, 32'h0000_0000);
        `CHK(pollActive, 1'b1)
        $display("software reset test done");
        runCmd(CMD_READ, 13'h0200, 8'h05, 8'ha0, 8'h20, 0);
        runCmd(CMD_READ, 13'h0c00, 8'h05, 8'h20, 8'h00, 0);
        runCmd(CMD_READ, 13'h0980, 8'h05, 8'h14, 8'h00, 0);
        runCmd(CMD_READ_ID, 13'h0040, 8'h05, 8'h04, 8'h00, 0);
        runCmd(CMD_READ_TRACK, 13'h0020, 8'h05, 8'h04, 8'h00, 0);
        runCmd(CMD_READ, 13'h0810, 8'h05, 8'h00, 8'h40, 0);
        runCmd(CMD_READ_DEL, 13'h0808, 8'h05, 8'h00, 8'h40, 0);
        runCmd(CMD_READ, 13'h0808, 8'h05, 8'h00, 8'h00, 0);
        runCmd(CMD_OTHER, 13'h0001, 8'hff, 8'h00, 8'h12, 0);
        runCmd(CMD_OTHER, 13'h0001, 8'h07, 8'h00, 8'h10, 0);
        runCmd(CMD_OTHER, 13'h0002, 8'h05, 8'h01, 8'h01, 0);
        runCmd(CMD_OTHER, 13'h0000, 8'h05, 8'h01, 8'h00, 2);
        runCmd(CMD_OTHER, 13'h0000, 8'h05, 8'h00, 8'h00, 1);
        runCmd(CMD_OTHER, 13'h1000, 8'h05, 8'h80, 8'h00, 0);
        runCmd(CMD_WRITE, 13'h0000, 8'h05, 8'h80, 8'h00, 0);
        wpLevel <= 1'b1;
        trk0Level <= 1'b1;
        trk.headSelect <= 1'b0;
        trk.driveSelect <= 2'h1;
        cyc(8);
        runCmd(CMD_WRITE, 13'h0800, 8'h05, 8'h02, 8'h00, 0);
        runCmd(CMD_WRITE_DEL, 13'h0800, 8'h05, 8'h02, 8'h00, 0);
        runCmd(CMD_FORMAT, 13'h0000, 8'h05, 8'h02, 8'h00, 0);
        runCmd(CMD_OTHER, 13'h0000, 8'h05, 8'h00, 8'h00, 0);
        wpLevel <= 1'b0;
        apb(`FRS_ADDR_SPECIFY, 1'b1, 32'h0000_005a);
        apb(`FRS_ADDR_CONFIG, 1'b1, 32'h0000_0001);
        apb(`FRS_ADDR_CTRL, 1'b1, 32'h0000_0004);
        cyc(2);
        `CHK(powerDown, 1'b1)
        cmdStart <= 1'b1;
        cmdKind <= CMD_WRITE;
        @(posedge mclk);
        cmdStart <= 1'b0;
        cmdDone <= 1'b1;
        @(posedge mclk);
        cmdDone <= 1'b0;
        systemResetPin_n <= 1'b0;
        cyc(8);
        systemResetPin_n <= 1'b1;
        cyc(8);
        `CHK(coreReset, 1'b1)
        `CHK(resultPhase, 1'b0)
        `CHK(powerDown, 1'b0)
        rd(`FRS_ADDR_CTRL, 32'h0000_0001);
        rd(`FRS_ADDR_SPECIFY, 32'h0000_005a);
        rd(`FRS_ADDR_CONFIG, 32'h0000_0000);
        apb(`FRS_ADDR_CTRL, 1'b1, 32'h0000_0003);
        cyc(6);
        `CHK(coreReset, 1'b1)
        rd(`FRS_ADDR_CTRL, 32'h0000_0001);
        apb(`FRS_ADDR_CTRL, 1'b1, 32'h0000_0000);
        cyc(4);
        `CHK(coreReset, 1'b0)
        `CHK(pollActive, 1'b1)
        $display("pin reset test done");
        results();
    end
endmodule : floppy_result_status_reset_tb

// [verification/frs_drive_model.sv]
`timescale 1ns/10ps
module frs_drive_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // bench requests
    input wire logic idxReq,
    input wire logic wpLevel,
    input wire logic trk0Level,
    // drive cable pins
    output logic writeProtectPin,
    output logic trackZeroPin,
    output logic rotationMarkerPin_n
);
    logic [2:0] idxCnt;
    assign writeProtectPin = wpLevel;
    assign trackZeroPin = trk0Level;
    // index hole passes for four cycles, pin low meanwhile
    assign rotationMarkerPin_n = (idxCnt == 3'h0);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            idxCnt <= 3'h0;
        end else if (idxReq) begin
            idxCnt <= 3'h4;
        end else if (idxCnt != 3'h0) begin
            idxCnt <= idxCnt - 3'h1;
        end
    end
endmodule : frs_drive_model
